/* File: bench/i2cj_bus_join_properties.sv */
`timescale 1ns/10ps
module i2cj_bus_join_properties
(
    input wire       clk,
    input wire       rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       serial_clock_pin_in,
    input wire       serial_clock_pin_out,
    input wire       serial_clock_pin_oe,
    input wire       serial_data_pin_in,
    input wire       serial_data_pin_out,
    input wire       serial_data_pin_oe,
    input wire       bus_interface_irq
);
    reg       en_q;
    reg       trig_q;
    reg       ien_q;
    reg [6:0] en_cnt;
    wire      cw  = wr && addr == 3'h0;
    wire      drv = serial_data_pin_oe | serial_clock_pin_oe;

    // Shadow of what software wrote
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_q   <= 1'b0;
            trig_q <= 1'b0;
            ien_q  <= 1'b0;
            en_cnt <= 7'h00;
        end
        else
        begin
            if (cw)
                en_q <= wdata[7];
            if (cw && (!wdata[7] || wdata[6]))
                trig_q <= 1'b0;
            else if (cw && en_q && wdata[1])
                trig_q <= 1'b1;
            if (cw && wdata[7] && !en_q)
                en_cnt <= 7'h00;
            else if (en_cnt != 7'h7f)
                en_cnt <= en_cnt + 7'h01;
            if (wr && addr == 3'h6)
                ien_q <= |wdata[2:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_EARLY_NO_ACK:
    assert property (en_q && !trig_q && en_cnt < 7'd80
        |-> !serial_data_pin_oe)
        else $error("Data line pulled inside release window");
    AST_RELEASE_FREES:
    assert property (cw && wdata[6] |-> ##2 !drv [*2])
        else $error("Pins still driven after release");
    AST_OFF_QUIET:
    assert property (!en_q && !$past(en_q) |-> !drv)
        else $error("Pins driven while disabled");
    AST_ACK_ONE_BIT:
    assert property ($rose(serial_data_pin_oe) && !trig_q
        |-> serial_data_pin_oe [*3] ##[1:12] !serial_data_pin_oe)
        else $error("Acknowledge length wrong");
    AST_OUT_LOW:
    assert property (!serial_data_pin_out && !serial_clock_pin_out)
        else $error("Open drain output not low");
    AST_IRQ_MASKED:
    assert property (!ien_q && !$past(ien_q) |-> !bus_interface_irq)
        else $error("Interrupt high while all sources masked");
    AST_RDATA_ZERO:
    assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("Read data outside read cycle");
endmodule // i2cj_bus_join_properties

bind i2cj_bus_join i2cj_bus_join_properties u_props
(
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
    .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe,
    .bus_interface_irq
);

/* File: bench/i2cj_bus_peer.sv */
`timescale 1ns/10ps
module i2cj_bus_peer
(
    input  wire scl,
    input  wire sda,
    output reg  scl_oe,
    output reg  sda_oe
);
    localparam integer Q = 200;
    integer i;

    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // Data falls while clock is high
    task start_c;
    begin
        #3 sda_oe = 1'b1;
        #(2*Q);
    end
    endtask

    // Byte MSB first, ninth clock samples acknowledge
    task send(input [7:0] b, output ack);
    begin
        #3;
        for (i = 7; i >= 0; i = i - 1)
        begin
            scl_oe = 1'b1;
            #Q sda_oe = ~b[i];
            #Q scl_oe = 1'b0;
            #(2*Q);
        end
        scl_oe = 1'b1;
        #Q sda_oe = 1'b0;
        #Q scl_oe = 1'b0;
        #Q ack = sda;
        #Q scl_oe = 1'b1;
    end
    endtask

    // Data rises while clock is high
    task stop_c;
    begin
        #Q sda_oe = 1'b1;
        #Q scl_oe = 1'b0;
        #Q sda_oe = 1'b0;
        #(2*Q);
    end
    endtask
endmodule // i2cj_bus_peer

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`include "i2cj_defs.vh"
module tb_top;
    reg        clk;
    reg        rst;
    reg  [2:0] addr;
    reg  [7:0] wdata;
    reg        wr;
    reg        rd;
    wire [7:0] rdata;
    wire       scl_oe;
    wire       sda_oe;
    wire       irq;
    wire       p_scl_oe;
    wire       p_sda_oe;
    wire       scl_w = ~(scl_oe | p_scl_oe);
    wire       sda_w = ~(sda_oe | p_sda_oe);
    reg  [7:0] exp_q[$];
    integer    errors;
    integer    check_count;
    integer    seed;
    integer    n;
    integer    q;
    reg        rd_seen;
    reg        ack;
    reg  [7:0] v;

    i2cj_bus_join DUT
    (
        .clk                  (clk),
        .rst                  (rst),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .serial_clock_pin_in  (scl_w),
        .serial_clock_pin_out (),
        .serial_clock_pin_oe  (scl_oe),
        .serial_data_pin_in   (sda_w),
        .serial_data_pin_out  (),
        .serial_data_pin_oe   (sda_oe),
        .bus_interface_irq    (irq)
    );

    i2cj_bus_peer peer
    (
        .scl    (scl_w),
        .sda    (sda_w),
        .scl_oe (p_scl_oe),
        .sda_oe (p_sda_oe)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input [7:0] got, input [7:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task stop_test;
    begin
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    task wr_reg(input [2:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    end
    endtask

    task rd_reg(input [2:0] a, input [7:0] e);
    begin
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
            chk(rdata, exp_q.pop_front());
        rd_seen = rd;
    end

    initial
    begin
        #3000000;
        errors = errors + 1;
        stop_test;
    end

    initial
    begin
        rst = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        errors = 0;
        check_count = 0;
        seed = 49;
        rd_seen = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 8; n = n + 1)
            rd_reg(n[2:0], 8'h00);
        n = $random(seed);
        v = n[7:0] & 8'h0b;
        q = (v[3] ? `I2CJ_QTR_FAST : `I2CJ_QTR_STD) << v[1:0];
        wr_reg(3'h1, v);
        wr_reg(3'h2, 8'h01);
        rd_reg(3'h1, v);
        rd_reg(3'h2, 8'h01);
        wr_reg(3'h2, 8'h00);
        // Join with a start already on the wire, then release
        peer.start_c;
        wr_reg(3'h0, 8'h80);
        wr_reg(3'h1, ~v & 8'h0b);
        rd_reg(3'h1, v);
        rd_reg(3'h3, 8'h60);
        wr_reg(3'h0, 8'hc0);
        peer.send(8'hf0, ack);
        chk({7'h00, ack}, 8'h01);
        peer.stop_c;
        wr_reg(3'h0, 8'h00);
        // Join without release: extension code answered
        peer.start_c;
        wr_reg(3'h0, 8'h80);
        repeat (90) @(posedge clk);
        peer.send(8'hf0, ack);
        chk({7'h00, ack}, 8'h00);
        peer.stop_c;
        wr_reg(3'h0, 8'h00);
        // Reserved start without stop interrupt stays waiting
        wr_reg(3'h0, 8'h80);
        peer.start_c;
        wr_reg(3'h0, 8'h82);
        peer.stop_c;
        repeat (40) @(posedge clk);
        rd_reg(3'h0, 8'h82);
        chk({7'h00, sda_oe | scl_oe}, 8'h00);
        wr_reg(3'h0, 8'hc0);
        rd_reg(3'h0, 8'h80);
        // Reserved start launched by data write after stop irq
        wr_reg(3'h6, 8'h01);
        wr_reg(3'h0, 8'h90);
        peer.start_c;
        wr_reg(3'h0, 8'h92);
        peer.stop_c;
        for (n = 0; n < 100 && irq !== 1'b1; n = n + 1)
            @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        n = $random(seed);
        wr_reg(3'h4, n[7:0]);
        for (n = 0; n < 4 * q + 20 && sda_oe !== 1'b1; n = n + 1)
            @(posedge clk);
        chk({7'h00, sda_oe}, 8'h01);
        repeat (3) @(posedge clk);
        rd_reg(3'h3, 8'hc0);
        repeat (40 * q + 50) @(posedge clk);
        rd_reg(3'h0, 8'h90);
        wr_reg(3'h0, 8'h91);
        repeat (4 * q + 50) @(posedge clk);
        rd_reg(3'h0, 8'h90);
        wr_reg(3'h6, 8'h00);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        wr_reg(3'h7, 8'h07);
        rd_reg(3'h5, 8'h00);
        repeat (3) @(posedge clk);
        stop_test;
    end
endmodule // tb_top

/* File: core/i2cj_bus_join.v */
`timescale 1ns/10ps
`include "i2cj_defs.vh"

module i2cj_bus_join
(
    input  wire       clk,
    input  wire       rst,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       serial_clock_pin_in,
    output reg        serial_clock_pin_out,
    output reg        serial_clock_pin_oe,
    input  wire       serial_data_pin_in,
    output reg        serial_data_pin_out,
    output reg        serial_data_pin_oe,
    output reg        bus_interface_irq
);

    localparam [7:0] S_IDLE  = 8'h01;
    localparam [7:0] S_START = 8'h02;
    localparam [7:0] S_BITS  = 8'h04;
    localparam [7:0] S_ACK   = 8'h08;
    localparam [7:0] S_HOLD  = 8'h10;
    localparam [7:0] S_STOP  = 8'h20;
    localparam [7:0] S_SLAVE = 8'h40;
    localparam [7:0] S_RESV  = 8'h80;

    reg        operation_enable_bit;
    reg        bus_release_bit;
    reg        stop_detect_irq_enable;
    reg        start_trigger_bit;
    reg        stop_trigger_bit;
    reg        speed_mode_select;
    reg        clock_select_hi;
    reg        clock_select_lo;
    reg        clock_extension_bit;
    reg [7:0]  shift;
    reg [7:0]  state;
    reg        resv_ready;
    reg [1:0]  phase;
    reg [9:0]  qcnt;
    reg [3:0]  bitcnt;
    reg        busy;
    reg        ack_rcvd;
    reg [6:0]  en_cnt;
    reg [2:0]  irq_stat;
    reg [2:0]  irq_en;
    reg [2:0]  irq_set;
    reg [7:0]  next_rdata;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    wire wr_ctrl  = wr && addr == `I2CJ_A_CTRL;
    wire wr_shift = wr && addr == `I2CJ_A_SHIFT;
    wire wr_clr   = wr && addr == `I2CJ_A_IRQCLR;
    wire tick     = qcnt == 10'h000;
    wire master_flag = (state & (S_START | S_BITS | S_ACK | S_HOLD | S_STOP))
                       != 8'h00;
    wire enable_rise = wr_ctrl && wdata[`I2CJ_B_ENABLE]
                       && !operation_enable_bit;

    // Quarter period of the transfer clock in cycles
    function [9:0] qtr_cycles;
        input       fast;
        input [1:0] sel;
        input       ext;
        reg   [9:0] base;
        begin
            base = fast ? `I2CJ_QTR_FAST : `I2CJ_QTR_STD;
            base = base << sel;
            qtr_cycles = ext ? {1'b0, base[9:1]} : base;
        end
    endfunction

    i2cj_line_mon u_mon
    (
        .clk       (clk),
        .rst       (rst),
        .scl_in    (serial_clock_pin_in),
        .sda_in    (serial_data_pin_in),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // Register read mux
    always @*
    begin
        next_rdata = 8'h00;
        if (addr == `I2CJ_A_CTRL)
            next_rdata = {operation_enable_bit, bus_release_bit, 1'b0,
                          stop_detect_irq_enable, 2'b00,
                          start_trigger_bit, stop_trigger_bit};
        else if (addr == `I2CJ_A_CLKSEL)
            next_rdata = {4'h0, speed_mode_select, 1'b0,
                          clock_select_hi, clock_select_lo};
        else if (addr == `I2CJ_A_EXPAND)
            next_rdata = {7'h00, clock_extension_bit};
        else if (addr == `I2CJ_A_STATUS)
            next_rdata = {master_flag, busy, state == S_SLAVE, ack_rcvd,
                          4'h0};
        else if (addr == `I2CJ_A_SHIFT)
            next_rdata = shift;
        else if (addr == `I2CJ_A_IRQSTAT)
            next_rdata = {5'h00, irq_stat};
        else if (addr == `I2CJ_A_IRQEN)
            next_rdata = {5'h00, irq_en};
    end

    // Interrupt events
    always @*
    begin
        irq_set = 3'h0;
        irq_set[`I2CJ_I_STOP]  = stop_det && stop_detect_irq_enable;
        irq_set[`I2CJ_I_START] = start_det;
        irq_set[`I2CJ_I_BYTE]  = (state == S_ACK) && tick
                                 && phase == 2'd3;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata                  <= `I2CJ_RST_BYTE;
            operation_enable_bit   <= 1'b0;
            bus_release_bit        <= 1'b0;
            stop_detect_irq_enable <= 1'b0;
            start_trigger_bit      <= 1'b0;
            stop_trigger_bit       <= 1'b0;
            speed_mode_select      <= 1'b0;
            clock_select_hi        <= 1'b0;
            clock_select_lo        <= 1'b0;
            clock_extension_bit    <= 1'b0;
            shift                  <= `I2CJ_RST_BYTE;
            state                  <= S_IDLE;
            resv_ready             <= 1'b0;
            phase                  <= 2'd0;
            qcnt                   <= 10'h000;
            bitcnt                 <= 4'h0;
            busy                   <= 1'b0;
            ack_rcvd               <= 1'b0;
            en_cnt                 <= 7'h00;
            irq_stat               <= `I2CJ_RST_IRQ;
            irq_en                 <= `I2CJ_RST_IRQ;
            bus_interface_irq      <= 1'b0;
            serial_clock_pin_out   <= 1'b0;
            serial_clock_pin_oe    <= 1'b0;
            serial_data_pin_out    <= 1'b0;
            serial_data_pin_oe     <= 1'b0;
        end
        else
        begin
            rdata <= rd ? next_rdata : 8'h00;
            bus_release_bit <= 1'b0;
            irq_stat <= (irq_stat & ~(wr_clr ? wdata[2:0] : 3'h0))
                        | irq_set;
            bus_interface_irq <= |(irq_stat & irq_en);
            if (wr && addr == `I2CJ_A_IRQEN)
                irq_en <= wdata[2:0];
            // Clock selection is locked while enabled
            if (!operation_enable_bit)
            begin
                if (wr && addr == `I2CJ_A_CLKSEL)
                begin
                    speed_mode_select <= wdata[`I2CJ_B_SPEED];
                    clock_select_hi   <= wdata[`I2CJ_B_CLHI];
                    clock_select_lo   <= wdata[`I2CJ_B_CLLO];
                end
                if (wr && addr == `I2CJ_A_EXPAND)
                    clock_extension_bit <= wdata[`I2CJ_B_CLX];
            end
            if (wr_shift)
                shift <= wdata;
            if (en_cnt != `I2CJ_REL_MAX && operation_enable_bit)
                en_cnt <= en_cnt + 7'd1;
            if (start_det)
                busy <= 1'b1;
            if (stop_det)
                busy <= 1'b0;
            if (wr_ctrl)
            begin
                operation_enable_bit   <= wdata[`I2CJ_B_ENABLE];
                stop_detect_irq_enable <= wdata[`I2CJ_B_SPIE];
                if (!start_trigger_bit && operation_enable_bit)
                    start_trigger_bit <= wdata[`I2CJ_B_STT];
                if (!stop_trigger_bit && operation_enable_bit)
                    stop_trigger_bit <= wdata[`I2CJ_B_SPT];
            end
            // Quarter timer rests in hold so the next phase starts clean
            if (master_flag && state != S_HOLD)
            begin
                if (tick)
                begin
                    qcnt  <= qtr_cycles(speed_mode_select,
                                        {clock_select_hi, clock_select_lo},
                                        clock_extension_bit);
                    phase <= phase + 2'd1;
                end
                else
                    qcnt <= qcnt - 10'd1;
            end
            else
            begin
                qcnt  <= 10'h000;
                phase <= 2'd0;
            end
            case (state)
            S_IDLE:
            begin
                if (start_det)
                begin
                    state  <= S_SLAVE;
                    bitcnt <= 4'h0;
                end
                else if (start_trigger_bit)
                    state <= busy ? S_RESV : S_START;
                else if (stop_trigger_bit)
                    stop_trigger_bit <= 1'b0;
            end
            S_START:
            begin
                if (tick)
                begin
                    if (phase == 2'd0)
                        serial_data_pin_oe <= 1'b0;
                    else if (phase == 2'd1)
                        serial_clock_pin_oe <= 1'b0;
                    else if (phase == 2'd2)
                        serial_data_pin_oe <= 1'b1;
                    else
                    begin
                        serial_clock_pin_oe <= 1'b1;
                        start_trigger_bit   <= 1'b0;
                        state               <= S_BITS;
                        bitcnt              <= 4'h0;
                    end
                end
            end
            S_BITS:
            begin
                if (tick)
                begin
                    if (phase == 2'd0)
                        serial_data_pin_oe <= ~shift[7];
                    else if (phase == 2'd1)
                        serial_clock_pin_oe <= 1'b0;
                    else if (phase == 2'd3)
                    begin
                        serial_clock_pin_oe <= 1'b1;
                        shift  <= {shift[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7)
                            state <= S_ACK;
                    end
                end
            end
            S_ACK:
            begin
                if (tick)
                begin
                    if (phase == 2'd0)
                        serial_data_pin_oe <= 1'b0;
                    else if (phase == 2'd1)
                        serial_clock_pin_oe <= 1'b0;
                    else if (phase == 2'd3)
                    begin
                        ack_rcvd            <= ~sda_s;
                        serial_clock_pin_oe <= 1'b1;
                        state               <= S_HOLD;
                    end
                end
            end
            S_HOLD:
            begin
                if (wr_shift)
                begin
                    state  <= S_BITS;
                    bitcnt <= 4'h0;
                end
                else if (start_trigger_bit)
                    state <= S_START;
                else if (stop_trigger_bit)
                    state <= S_STOP;
            end
            S_STOP:
            begin
                if (tick)
                begin
                    if (phase == 2'd0)
                        serial_data_pin_oe <= 1'b1;
                    else if (phase == 2'd1)
                        serial_clock_pin_oe <= 1'b0;
                    else if (phase == 2'd2)
                        serial_data_pin_oe <= 1'b0;
                    else
                    begin
                        stop_trigger_bit <= 1'b0;
                        state            <= S_IDLE;
                    end
                end
            end
            S_SLAVE:
            begin
                if (scl_rise && bitcnt < 4'h8)
                begin
                    shift  <= {shift[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end
                if (scl_fall && bitcnt == 4'h8)
                begin
                    // Extension code answers, not before the release window
                    if (shift[7:3] == `I2CJ_EXT_CODE
                        && en_cnt == `I2CJ_REL_MAX)
                    begin
                        serial_data_pin_oe <= 1'b1;
                        bitcnt             <= 4'h9;
                    end
                    else
                        state <= S_IDLE;
                end
                if (scl_fall && bitcnt == 4'h9)
                begin
                    serial_data_pin_oe <= 1'b0;
                    state              <= S_IDLE;
                end
                // A request made while another master held the bus waits
                if (stop_det)
                begin
                    state <= start_trigger_bit ? S_RESV : S_IDLE;
                    resv_ready <= start_trigger_bit
                                  && stop_detect_irq_enable;
                end
            end
            S_RESV:
            begin
                if (stop_det && stop_detect_irq_enable)
                    resv_ready <= 1'b1;
                if (resv_ready && wr_shift)
                begin
                    resv_ready <= 1'b0;
                    state      <= S_START;
                end
                // Without the stop interrupt the request waits here
            end
            default:
                state <= S_IDLE;
            endcase
            // Enable with data low and clock high is a start
            if (enable_rise)
            begin
                en_cnt <= 7'h00;
                if (scl_s && !sda_s)
                begin
                    state  <= S_SLAVE;
                    bitcnt <= 4'h0;
                    busy   <= 1'b1;
                end
            end
            // Release or disable abandons all activity
            if ((wr_ctrl && wdata[`I2CJ_B_RELEASE]
                 && operation_enable_bit)
                || !operation_enable_bit)
            begin
                if (wr_ctrl && wdata[`I2CJ_B_RELEASE])
                    bus_release_bit <= 1'b1;
                if (!enable_rise)
                    state <= S_IDLE;
                resv_ready          <= 1'b0;
                start_trigger_bit   <= 1'b0;
                stop_trigger_bit    <= 1'b0;
                serial_data_pin_oe  <= 1'b0;
                serial_clock_pin_oe <= 1'b0;
            end
        end
    end

endmodule // i2cj_bus_join

/* File: core/i2cj_line_mon.v */
`timescale 1ns/10ps
`include "i2cj_defs.vh"

module i2cj_line_mon
(
    input  wire clk,
    input  wire rst,
    input  wire scl_in,
    input  wire sda_in,
    output reg  scl_s,
    output reg  sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);

    reg scl_m;
    reg sda_m;
    reg scl_p;
    reg sda_p;

    // Two-stage synchronisers, then one history stage
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_m <= 1'b1;
            sda_m <= 1'b1;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_m <= scl_in;
            sda_m <= sda_in;
            scl_s <= scl_m;
            sda_s <= sda_m;
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

endmodule // i2cj_line_mon

/* File: inc/i2cj_defs.vh */
`ifndef I2CJ_DEFS_VH
`define I2CJ_DEFS_VH

// Register offsets
`define I2CJ_A_CTRL    3'h0
`define I2CJ_A_CLKSEL  3'h1
`define I2CJ_A_EXPAND  3'h2
`define I2CJ_A_STATUS  3'h3
`define I2CJ_A_SHIFT   3'h4
`define I2CJ_A_IRQSTAT 3'h5
`define I2CJ_A_IRQEN   3'h6
`define I2CJ_A_IRQCLR  3'h7

// Control register fields
`define I2CJ_B_ENABLE  7
`define I2CJ_B_RELEASE 6
`define I2CJ_B_SPIE    4
`define I2CJ_B_STT     1
`define I2CJ_B_SPT     0

// Clock select and expansion fields
`define I2CJ_B_SPEED   3
`define I2CJ_B_CLHI    1
`define I2CJ_B_CLLO    0
`define I2CJ_B_CLX     0

// Status register fields
`define I2CJ_B_MASTER  7
`define I2CJ_B_BUSY    6
`define I2CJ_B_SLAVE   5
`define I2CJ_B_ACKRX   4

// Interrupt status fields
`define I2CJ_I_STOP    0
`define I2CJ_I_BYTE    1
`define I2CJ_I_START   2

// Reset values
`define I2CJ_RST_BYTE  8'h00
`define I2CJ_RST_IRQ   3'h0

// Timing
`define I2CJ_CLK_NS      100
`define I2CJ_QTR_STD_NS  2500
`define I2CJ_QTR_FAST_NS 625
`define I2CJ_QTR_STD     10'd25
`define I2CJ_QTR_FAST    10'd6
`define I2CJ_REL_MIN     7'd4
`define I2CJ_REL_MAX     7'd80

// Extension code prefix
`define I2CJ_EXT_CODE  5'h1e

`endif
